// ---- logic/aom_defs.svh ----
// register offsets, field positions, reset values and timing of the output mode block
`ifndef AOM_DEFS_SVH
`define AOM_DEFS_SVH

`define AOM_CTRL_OFS 8'h00
`define AOM_STATUS_OFS 8'h04
`define AOM_RESULT_OFS 8'h08
`define AOM_COUNT_OFS 8'h0C

`define AOM_CTRL_SWAP_BIT 0
`define AOM_CTRL_CODE_BIT 1
`define AOM_CTRL_PORT_BIT 2
`define AOM_CTRL_FAST_BIT 3
`define AOM_CTRL_LOWP_BIT 4
`define AOM_CTRL_RST 5'h02

`define AOM_STAT_MODE_LSB 0
`define AOM_STAT_LATE_BIT 2
`define AOM_STAT_RAC_BIT 3
`define AOM_STAT_DIV_LSB 4
`define AOM_STAT_EXT_BIT 6
`define AOM_STAT_RDC_BIT 7

`define AOM_CLK_PERIOD_NS 10
`define AOM_SPACING_MAX_NS 1000000

`endif

// ---- logic/aom_pkg.sv ----
// types of the output mode block
package aom_pkg;

  typedef enum logic [1:0] {
    AOM_MODE_NORMAL = 2'b00,
    AOM_MODE_FAST = 2'b01,
    AOM_MODE_LOW_POWER = 2'b10,
    AOM_MODE_UNDEFINED = 2'b11
  } aom_mode_e;

  typedef struct packed {
    logic ctrl_swap;
    logic ctrl_code;
    logic ctrl_port;
    logic ctrl_fast;
    logic ctrl_lowp;
    aom_mode_e mode;
    logic [15:0] result;
    logic [15:0] d_out;
    logic [15:0] d_oe;
    logic [3:0][2:0] sync;
    logic [3:0] filt;
    logic [1:0] divider;
    logic late;
    logic seen_conv;
    logic [19:0] spacing_cnt;
    logic [15:0] conv_count;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
  } aom_state_s;

endpackage : aom_pkg

// ---- logic/aom_output_mode.sv ----
// output formatting, mode selection and pin steering of the converter result port
//
// Behaviour
// - swap select low: low byte on lines 7..0; high swaps the halves.
// - code select high gives straight binary; low inverts the MSB.
// - fast select high, low-power low: fastest mode; host keeps minimum rate.
// - fast select low: accuracy held for any rate, no minimum imposed.
// - low-power high, fast low: reduced-power mode scaling with sample rate.
// - port select low: parallel port; high: serial mode reuses data pins.
// - lines 0 and 1 carry bits 0,1 in parallel; released in serial.
// - parallel mode drives bits 2 and 3 on lines 2 and 3.
// - serial master read-after-convert: lines 2,3 are divider inputs, else released.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "aom_defs.svh"

module aom_output_mode #(
  parameter int unsigned SPACING_MAX_CYC = `AOM_SPACING_MAX_NS / `AOM_CLK_PERIOD_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic conv_start,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic [15:0] d_in,
  output logic [15:0] d_out,
  output logic [15:0] d_oe,
  output aom_pkg::aom_mode_e mode_select,
  output logic [1:0] serial_clock_divider,
  output logic spacing_late
);
  import aom_pkg::*;

  localparam logic [19:0] SPACING_LIMIT = 20'(SPACING_MAX_CYC);
  // pin index of each synchronised strap: divider 0, divider 1, clock source, read mode
  localparam int unsigned PIN_DIV0 = 2;
  localparam int unsigned PIN_DIV1 = 3;
  localparam int unsigned PIN_EXT = 4;
  localparam int unsigned PIN_RDC = 7;
  // reset image of the control word, split per field
  localparam logic [4:0] CTRL_RST = `AOM_CTRL_RST;
  localparam logic RST_SWAP = CTRL_RST[`AOM_CTRL_SWAP_BIT];
  localparam logic RST_CODE = CTRL_RST[`AOM_CTRL_CODE_BIT];
  localparam logic RST_PORT = CTRL_RST[`AOM_CTRL_PORT_BIT];
  localparam logic RST_FAST = CTRL_RST[`AOM_CTRL_FAST_BIT];
  localparam logic RST_LOWP = CTRL_RST[`AOM_CTRL_LOWP_BIT];
  // pin enable words of the two port types
  localparam logic [15:0] OE_PARALLEL = 16'hFFFF;
  localparam logic [15:0] OE_SERIAL = 16'h0000;

  aom_state_s st;
  aom_state_s next_st;

  logic addr_phase;
  logic serial_rac;
  logic [15:0] coded;
  logic [3:0] pin_sel;
  logic [31:0] read_word;
  logic [3:0] sync_agree;
  logic fast_armed;
  logic late_event;

  // a transfer is taken only while the bus is ready
  assign addr_phase = hsel && htrans[1] && hready;
  assign pin_sel = {d_in[PIN_RDC], d_in[PIN_EXT], d_in[PIN_DIV1], d_in[PIN_DIV0]};

  // the watchdog only runs in the fastest mode, once a conversion has been seen in any mode since reset
  assign fast_armed = st.mode == AOM_MODE_FAST && st.seen_conv;
  assign late_event = fast_armed && !conv_start &&
    st.spacing_cnt == SPACING_LIMIT - 20'h00001;

  // stages two and three agree: the filtered level may follow them
  for (genvar g = 0; g < 4; g++) begin : g_pin_agree
    assign sync_agree[g] = st.sync[g][1] == st.sync[g][2];
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    read_word = 32'h0000_0000;

    // three-stage synchronisers, filtered value moves once stages two and three agree
    for (int i = 0; i < 4; i++) begin
      next_st.sync[i] = {st.sync[i][1:0], pin_sel[i]};
      if (sync_agree[i]) begin
        next_st.filt[i] = st.sync[i][2];
      end
    end

    // data phase of a write lands here
    if (st.ap_valid && st.ap_write) begin
      case (st.ap_addr)
        `AOM_CTRL_OFS: begin
          // pins and mode follow at this same edge
          next_st.ctrl_swap = hwdata[`AOM_CTRL_SWAP_BIT];
          next_st.ctrl_code = hwdata[`AOM_CTRL_CODE_BIT];
          next_st.ctrl_port = hwdata[`AOM_CTRL_PORT_BIT];
          next_st.ctrl_fast = hwdata[`AOM_CTRL_FAST_BIT];
          next_st.ctrl_lowp = hwdata[`AOM_CTRL_LOWP_BIT];
        end
        `AOM_STATUS_OFS: begin
          // write one clears the late flag
          if (hwdata[`AOM_STAT_LATE_BIT]) begin
            next_st.late = 1'b0;
          end
        end
        default: begin
          // read-only and unmapped offsets ignore writes
        end
      endcase
    end

    // mode decode from the two selects
    case ({next_st.ctrl_lowp, next_st.ctrl_fast})
      2'b01: begin
        next_st.mode = AOM_MODE_FAST;
      end
      2'b10: begin
        next_st.mode = AOM_MODE_LOW_POWER;
      end
      2'b00: begin
        next_st.mode = AOM_MODE_NORMAL;
      end
      2'b11: begin
        // both selects high: shown as undefined, pins act as otherwise
        next_st.mode = AOM_MODE_UNDEFINED;
      end
      default: begin
        next_st.mode = AOM_MODE_NORMAL;
      end
    endcase

    // spacing watchdog, armed only in the fastest mode
    if (conv_start) begin
      next_st.seen_conv = 1'b1;
      next_st.spacing_cnt = 20'h00000;
    end else if (st.spacing_cnt != SPACING_LIMIT) begin
      // saturates, so one long gap flags once and never wraps
      next_st.spacing_cnt = st.spacing_cnt + 20'h00001;
    end
    // a clear written in the same cycle loses against a new late event
    if (late_event) begin
      next_st.late = 1'b1;
    end
    // other modes never flag a slow host
    if (st.mode != AOM_MODE_FAST) begin
      next_st.spacing_cnt = 20'h00000;
    end

    // result capture with output coding
    // coding follows the control word in force as the result arrives
    if (result_valid) begin
      next_st.result = coded;
      next_st.conv_count = st.conv_count + 16'h0001;
    end

    // pin steering
    serial_rac = next_st.ctrl_port && !next_st.filt[2] && !next_st.filt[3];
    if (!next_st.ctrl_port) begin
      next_st.d_oe = OE_PARALLEL;
      if (next_st.ctrl_swap) begin
        next_st.d_out[7:0] = next_st.result[15:8];
        next_st.d_out[15:8] = next_st.result[7:0];
      end else begin
        next_st.d_out[7:0] = next_st.result[7:0];
        next_st.d_out[15:8] = next_st.result[15:8];
      end
    end else begin
      // serial mode: every data line released; lines 0,1 and 2,3 included
      next_st.d_oe = OE_SERIAL;
      next_st.d_out = 16'h0000;
    end
    // lines 2 and 3 stay driven only in parallel mode
    next_st.d_oe[3:2] = next_st.ctrl_port ? 2'b00 : 2'b11;
    // divider pins only mean something in master read-after-convert
    if (serial_rac) begin
      next_st.divider = next_st.filt[1:0];
    end else begin
      next_st.divider = 2'b00;
    end

    // address phase: latch and prepare read data from the updated state
    if (addr_phase) begin
      next_st.ap_valid = 1'b1;
      next_st.ap_write = hwrite;
      next_st.ap_addr = haddr[7:0];
    end else begin
      next_st.ap_valid = 1'b0;
      next_st.ap_write = 1'b0;
      next_st.ap_addr = 8'h00;
    end
    case (haddr[7:0])
      `AOM_CTRL_OFS: begin
        read_word[`AOM_CTRL_SWAP_BIT] = next_st.ctrl_swap;
        read_word[`AOM_CTRL_CODE_BIT] = next_st.ctrl_code;
        read_word[`AOM_CTRL_PORT_BIT] = next_st.ctrl_port;
        read_word[`AOM_CTRL_FAST_BIT] = next_st.ctrl_fast;
        read_word[`AOM_CTRL_LOWP_BIT] = next_st.ctrl_lowp;
      end
      `AOM_STATUS_OFS: begin
        // bits 6 and 7 report the filtered clock-source and read-mode pins
        read_word[`AOM_STAT_MODE_LSB +: 2] = next_st.mode;
        read_word[`AOM_STAT_LATE_BIT] = next_st.late;
        read_word[`AOM_STAT_RAC_BIT] = serial_rac;
        read_word[`AOM_STAT_DIV_LSB +: 2] = next_st.divider;
        read_word[`AOM_STAT_EXT_BIT] = next_st.filt[2];
        read_word[`AOM_STAT_RDC_BIT] = next_st.filt[3];
      end
      `AOM_RESULT_OFS: begin
        read_word[15:0] = next_st.result;
      end
      `AOM_COUNT_OFS: begin
        read_word[15:0] = next_st.conv_count;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
    if (addr_phase && !hwrite) begin
      next_st.hrdata = read_word;
    end
  end

  // straight binary or inverted msb
  always_comb begin
    coded = result_data;
    if (!st.ctrl_code) begin
      coded[15] = ~result_data[15];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // every line released and every counter cleared while in reset
      st.ctrl_swap <= RST_SWAP;
      st.ctrl_code <= RST_CODE;
      st.ctrl_port <= RST_PORT;
      st.ctrl_fast <= RST_FAST;
      st.ctrl_lowp <= RST_LOWP;
      st.mode <= AOM_MODE_NORMAL;
      st.result <= 16'h0000;
      st.d_out <= 16'h0000;
      st.d_oe <= 16'h0000;
      st.sync <= '0;
      st.filt <= 4'h0;
      st.divider <= 2'b00;
      st.late <= 1'b0;
      st.seen_conv <= 1'b0;
      st.spacing_cnt <= 20'h00000;
      st.conv_count <= 16'h0000;
      st.ap_valid <= 1'b0;
      st.ap_write <= 1'b0;
      st.ap_addr <= 8'h00;
      st.hrdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // every register answers at once: no wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  // pin and status outputs straight from the state register
  assign d_out = st.d_out;
  assign d_oe = st.d_oe;
  assign mode_select = st.mode;
  assign serial_clock_divider = st.divider;
  assign spacing_late = st.late;

endmodule : aom_output_mode

// ---- tb/aom_monitor.sv ----
// port assertions of the output mode block
`timescale 1ns/1ns
module aom_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic [15:0] d_in,
  input wire logic [15:0] d_out,
  input wire logic [15:0] d_oe,
  input wire aom_pkg::aom_mode_e mode_select,
  input wire logic [1:0] serial_clock_divider,
  input wire logic spacing_late
);
  import aom_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // serial pins left alone long enough for the filter
  sequence s_steady;
    (d_oe == 16'h0000 && $stable(d_in[7:2]))[*8];
  endsequence
  sequence s_ctrl_write;
    // a write address phase two edges back: its data phase moved the mode
    $past(hsel && htrans[1] && hwrite, 2);
  endsequence
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_oe_whole: assert property (d_oe == 16'h0000 || d_oe == 16'hFFFF)
    else $error("split enable");
  a_serial_quiet: assert property (d_oe == 16'h0000 |-> d_out == 16'h0000)
    else $error("lines driven in serial");
  a_div_parallel: assert property (d_oe != 16'h0000 |-> serial_clock_divider == 2'h0)
    else $error("divider in parallel");
  a_div_follow: assert property (s_steady |-> serial_clock_divider ==
    ((d_in[4] | d_in[7]) ? 2'h0 : d_in[3:2])) else $error("divider off pins");
  a_late_fast: assert property ($rose(spacing_late) |-> $past(mode_select) == AOM_MODE_FAST)
    else $error("late outside fast");
  a_mode_cause: assert property ($changed(mode_select) |-> s_ctrl_write)
    else $error("mode moved alone");
  a_result_bytes: assert property (result_valid && d_oe == 16'hFFFF |=>
    d_out[6:0] == $past(result_data[6:0]) || d_out[14:8] == $past(result_data[6:0]))
    else $error("result bytes lost");
endmodule : aom_monitor
////////////////////////////////////////////////////////////////////////////////
bind aom_output_mode aom_monitor u_aom_monitor (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hreadyout, .hresp, .result_valid, .result_data, .d_in, .d_out, .d_oe, .mode_select,
  .serial_clock_divider, .spacing_late);

// ---- tb/aom_host_model.sv ----
// host side: pin wire levels and conversion start pacing
`timescale 1ns/1ns
module aom_host_model (
  input wire logic hclk,
  input wire logic run,
  input wire logic [15:0] strap,
  input wire logic [15:0] d_out,
  input wire logic [15:0] d_oe,
  output logic [15:0] d_in,
  output logic conv_start
);
  logic [2:0] cnt = 3'h0;
  assign d_in = (d_oe & d_out) | (~d_oe & strap);
  always @(posedge hclk) begin
    cnt <= cnt + 3'h1;
    conv_start <= run && cnt == 3'h0;
  end
endmodule : aom_host_model

// ---- tb/testbench.sv ----
// self-checking bench of the output mode block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h", $time, a); end end
module testbench;
  import aom_pkg::*;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp, conv_start, result_valid, run;
  logic hclk, spacing_late;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, serial_clock_divider;
  logic [2:0] hsize;
  logic [15:0] result_data, d_in, d_out, d_oe, strap, e;
  aom_mode_e mode_select;
  int n_fail, checked, cycles;
  aom_output_mode #(.SPACING_MAX_CYC(20)) u_aom_output_mode (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .conv_start,
    .result_valid, .result_data, .d_in, .d_out, .d_oe, .mode_select, .serial_clock_divider,
    .spacing_late);
  aom_host_model u_aom_host_model (.hclk, .run, .strap, .d_out, .d_oe, .d_in, .conv_start);
  assign hready = hreadyout;
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, result_valid, result_data, strap, run} = '0;
    hsize = 3'h2;
    cyc(3);
    hresetn <= 1'h1;
    bus(1'h0, 8'h00, 32'h0);
    `CHK(rd, 32'h2)
    `CHK(d_oe, 16'hFFFF)
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, 8'h00, 32'(i));
      result_valid <= 1'h1;
      result_data <= 16'h9C3E;
      cyc(1);
      result_valid <= 1'h0;
      cyc(1);
      e = 16'h9C3E ^ {~i[1], 15'h0};
      if (i[0]) e = {e[7:0], e[15:8]};
      `CHK(d_out, e)
    end
    bus(1'h0, 8'h0C, 32'h0);
    `CHK(rd, 32'h4)
    bus(1'h0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    $display("test format done");
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, 8'h00, 32'(i * 8 + 2));
      bus(1'h0, 8'h04, 32'h0);
      `CHK(rd[1:0], 2'(i))
      `CHK(mode_select, aom_mode_e'(i))
    end
    $display("test modes done");
    bus(1'h1, 8'h00, 32'hA);
    run <= 1'h1;
    cyc(60);
    `CHK(spacing_late, 1'h0)
    run <= 1'h0;
    cyc(40);
    `CHK(spacing_late, 1'h1)
    bus(1'h1, 8'h00, 32'h2);
    bus(1'h1, 8'h04, 32'h4);
    cyc(40);
    `CHK(spacing_late, 1'h0)
    $display("test spacing done");
    strap <= 16'h0008;
    bus(1'h1, 8'h00, 32'h6);
    cyc(12);
    `CHK(d_oe, 16'h0000)
    `CHK(serial_clock_divider, 2'h2)
    strap <= 16'h0018;
    cyc(12);
    `CHK(serial_clock_divider, 2'h0)
    bus(1'h1, 8'h00, 32'h2);
    cyc(1);
    `CHK(d_oe, 16'hFFFF)
    $display("test serial done");
    summarize();
  end
endmodule : testbench
